// >>> sim/imct_monitor.sv
// checker of bus wire timing between the two ends, counted in bclk ticks
// assumes core_clk samples every wire and bclk is made from core_clk
`timescale 1ns/1ps
module imct_monitor (
  input wire logic        core_clk, // core clock
  input wire logic        nrst,     // reset, active low
  input wire logic        bclk,     // bus clock
  input wire logic        ale_n,    // address latch
  input wire logic [6:0]  la,       // upper address
  input wire logic [19:0] sa,       // system address
  input wire logic        sbhe_n,   // high byte
  input wire logic        memr_n,   // memory read
  input wire logic        memw_n,   // memory write
  input wire logic        smemr_n,  // sys memory read
  input wire logic        smemw_n,  // sys memory write
  input wire logic        ior_n,    // io read
  input wire logic        iow_n,    // io write
  input wire logic        iochrdy   // ready
);
  logic       cmd_n, tick, io_q, bclk_q, ale_q, cmd_q, rdy_q;
  logic [5:0] ale_t, cmd_t, off_t, rdy_t;
  assign cmd_n = memr_n & memw_n & smemr_n & smemw_n & ior_n & iow_n; // no strobe low
  assign tick  = bclk & ~bclk_q;
  function automatic logic [5:0] step(input logic [5:0] v, input logic clr, input logic t);
    return clr ? 6'h00 : ((t && v != 6'h3f) ? 6'(v + 6'h01) : v);
  endfunction
  // ticks since ale, command on, command off and ready return; all saturate
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      {bclk_q, io_q} <= 2'h0;
      {ale_q, cmd_q, rdy_q} <= 3'h7;
      {ale_t, cmd_t, off_t, rdy_t} <= 24'hffffff;
    end else begin
      {bclk_q, ale_q, cmd_q, rdy_q} <= {bclk, ale_n, cmd_n, iochrdy};
      ale_t <= step(ale_t, ale_q & ~ale_n, tick);
      cmd_t <= step(cmd_t, cmd_q & ~cmd_n, tick);
      off_t <= step(off_t, ~cmd_q & cmd_n, tick);
      rdy_t <= step(rdy_t, ~rdy_q & iochrdy, tick);
      if (cmd_q & ~cmd_n) begin
        io_q <= ~(ior_n & iow_n);
      end
    end
  end
  // ------------------------------------------------------------------
  // assertions; master events land on tick samples, so elapsed = count + 1
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_ale_on; $fell(ale_n); endsequence
  sequence s_cmd_on; $fell(cmd_n); endsequence
  sequence s_cmd_off; $rose(cmd_n); endsequence
  a_ale_width: assert property (s_ale_on |=> !ale_n [*7])
    else $error("ale released early");
  a_ale_to_cmd: assert property (s_cmd_on |-> ale_t >= 6'd1)
    else $error("command early after ale");
  a_ale_to_off: assert property (s_cmd_off |-> ale_t >= 6'd10)
    else $error("command ended early after ale");
  a_la_after_ale: assert property ($changed(la) |-> ale_t >= 6'd14)
    else $error("la changed early after ale");
  a_la_after_cmd: assert property ($changed(la) |-> cmd_t >= 6'd12)
    else $error("la changed early after command");
  a_cmd_width: assert property (s_cmd_off |-> cmd_t >= 6'd8)
    else $error("command too short");
  a_sa_hold: assert property ($changed(sa) |->
      cmd_t >= (io_q ? 6'd18 : 6'd9)) else $error("sa changed early");
  a_cmd_to_ale: assert property (s_ale_on |-> cmd_t >= 6'd9)
    else $error("ale early after command");
  a_cmd_repeat: assert property (s_cmd_on |-> cmd_t >= 6'd11)
    else $error("commands too close");
  a_off_to_cmd: assert property (s_cmd_on |-> off_t >= 6'd2)
    else $error("command early after negation");
  a_off_to_ale: assert property (s_ale_on |-> $past(cmd_n, 8))
    else $error("ale early after negation");
  a_wait_start: assert property ($fell(iochrdy) |->
      ale_t >= (sbhe_n ? 6'd14 : 6'd8)) else $error("ready pulled early");
  a_ready_to_off: assert property (s_cmd_off |-> iochrdy && rdy_t >= 6'd1)
    else $error("command ended early after ready");
endmodule

// >>> sim/isa_master_cycle_timing_tb.sv
// bench: master and slave ends joined by imct_bus_if, sweep and random waits
// assumes the verilog/ files and the checker are compiled first
`timescale 1ns/1ps
module isa_master_cycle_timing_tb;
  import imct_pkg::*;
  imct_bus_if  bus ();
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        req, req_wr, req_w16, req_zws, cfg_w16, ack, busy, done, done_wr, cap_sbhe;
  imct_kind_t  req_kind;
  logic [23:0] req_addr;
  logic [15:0] req_wdata, rdata, last_data, sl_data;
  logic [3:0]  cfg_wait;
  logic [5:0]  cap_st;
  logic        sl_wr;
  logic [6:0]  cap_la;
  logic [19:0] cap_sa;
  logic [31:0] seed = 32'h4f86;
  int          len = 0, last_len = 0, failures = 0, n_tests = 0, n_done = 0;
  wire  [5:0]  st = {bus.iow_n, bus.ior_n, bus.smemw_n, bus.smemr_n, bus.memw_n, bus.memr_n};

  always #(CORE_CLK_NS / 2) core_clk = ~core_clk;

  imct_master u_imct_master (.core_clk, .nrst, .req, .req_kind, .req_wr, .req_w16, .req_zws,
    .req_addr, .req_wdata, .ack, .rdata, .busy, .bus);
  imct_slave u_imct_slave (.core_clk, .nrst, .cfg_w16, .cfg_wait, .done, .done_wr,
    .last_data, .bus);
  imct_monitor u_imct_monitor (.core_clk, .nrst, .bclk(bus.bclk), .ale_n(bus.ale_n),
    .la(bus.la), .sa(bus.sa), .sbhe_n(bus.sbhe_n), .memr_n(bus.memr_n), .memw_n(bus.memw_n),
    .smemr_n(bus.smemr_n), .smemw_n(bus.smemw_n), .ior_n(bus.ior_n), .iow_n(bus.iow_n),
    .iochrdy(bus.iochrdy));

  // capture strobe pattern, addresses and low time of each command
  always @(posedge core_clk) begin
    if (st != CMD_IDLE) begin
      len <= len + 1;
      {cap_st, cap_la, cap_sa, cap_sbhe} <= {st, bus.la, bus.sa, bus.sbhe_n};
    end else if (len != 0) begin
      last_len <= len;
      len <= 0;
    end
    if (done) begin
      {sl_data, sl_wr} <= {last_data, done_wr};
      n_done <= n_done + 1;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // strobe low time in core cycles for a cycle class without waits
  function automatic int exp_len(input logic w16, input logic zws, input imct_kind_t k);
    int off;
    off = zws ? 11 : (w16 ? ((k == IMCT_IO) ? 12 : 11) : 16);
    return (off - 2) * 2 * BCLK_HALF;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one access with matching slave setup, then checks on wires and data
  task automatic acc(input imct_kind_t k, input logic wr, input logic w16, input logic zws,
                     input logic [23:0] a, input logic [15:0] d, input logic [3:0] wt);
    int i;
    int nd0;
    @(posedge core_clk);
    nd0 = n_done;
    {req_kind, req_wr, req_w16, req_zws, req_addr, req_wdata} <= {k, wr, w16, zws, a, d};
    {cfg_w16, cfg_wait, req} <= {w16, wt, 1'b1};
    for (i = 0; i < 600 && ack !== 1'b1; i++) @(negedge core_clk);
    @(posedge core_clk);
    req <= 1'b0;
    chk(i < 600, 1);
    chk(cap_st, 6'h3f ^ (6'h01 << {k, wr}));
    chk({cap_la, cap_sa, cap_sbhe}, {a[23:17], a[19:0], !(w16 | a[0])});
    if (wt == 4'h0) chk(last_len, exp_len(w16, zws, k));
    else chk(last_len >= exp_len(w16, zws, k), 1);
    if (!wr) chk(rdata, w16 ? d : {8'h00, d[7:0]});
    if (w16) chk(sl_data, d);
    else chk(sl_data, {d[7:0], d[7:0]});
    chk(n_done - nd0, 1);
    chk({busy, sl_wr}, {1'b0, wr});
  endtask

  // write then read back one random even address
  task automatic pair(input imct_kind_t k, input logic w16, input logic zws, input logic [3:0] wt);
    logic [23:0] a;
    seed = lfsr(seed);
    a = {seed[23:1], 1'b0};
    seed = lfsr(seed);
    acc(k, 1'b1, w16, zws, a, seed[15:0], wt);
    acc(k, 1'b0, w16, zws, a, seed[15:0], wt);
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence: reset, odd byte, class sweep, then random waits
  initial begin
    {req, req_wr, req_w16, req_zws, cfg_w16, cfg_wait, req_addr, req_wdata} = '0;
    req_kind = IMCT_MEM;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    // odd byte on an 8-bit slave rides the high lane back to the master
    acc(IMCT_MEM, 1'b1, 1'b0, 1'b0, 24'h0a0003, 16'h5a3c, 4'h0);
    acc(IMCT_MEM, 1'b0, 1'b0, 1'b0, 24'h0a0003, 16'h5a3c, 4'h0);
    $display("test odd byte done");
    for (int k = 0; k < 3; k++) begin
      for (int m = 0; m < 4; m++) begin
        pair(imct_kind_t'(k), m[1], m[0], 4'h0);
      end
    end
    $display("test class sweep done");
    for (int j = 0; j < 8; j++) begin
      seed = lfsr(seed);
      pair(imct_kind_t'(seed[1:0] % 2'd3), seed[6], 1'b0, 4'(1 + seed[5:2] % 15));
    end
    $display("test wait states done");
    results();
  end

  // cut a hang short
  initial begin
    repeat (40000) @(posedge core_clk);
    failures++;
    results();
  end
endmodule

// >>> verilog/imct_bus_if.sv
// bus wires between the isa master end and the isa slave end
// assumes the slave drives iochrdy open drain and sd floats high when undriven
`timescale 1ns/1ps
interface imct_bus_if;
  logic        bclk;
  logic        ale_n;
  logic [6:0]  la;
  logic [19:0] sa;
  logic        sbhe_n;
  logic        memr_n;
  logic        memw_n;
  logic        smemr_n;
  logic        smemw_n;
  logic        ior_n;
  logic        iow_n;
  logic [15:0] m_sd_o;
  logic        m_sd_oe;
  logic [15:0] s_sd_o;
  logic        s_sd_oe;
  logic        s_rdy_o;
  logic        s_rdy_oe;
  logic [15:0] sd;
  logic        iochrdy;

  // wire levels from the enables
  assign sd      = m_sd_oe ? m_sd_o : (s_sd_oe ? s_sd_o : imct_pkg::BUS_FLOAT);
  assign iochrdy = !(s_rdy_oe && !s_rdy_o);

  modport master (output bclk, ale_n, la, sa, sbhe_n, memr_n, memw_n, smemr_n,
                  smemw_n, ior_n, iow_n, m_sd_o, m_sd_oe, input sd, iochrdy);
  modport slave  (input bclk, ale_n, la, sa, sbhe_n, memr_n, memw_n, smemr_n,
                  smemw_n, ior_n, iow_n, sd, iochrdy, output s_sd_o, s_sd_oe,
                  s_rdy_o, s_rdy_oe);
endinterface

// >>> verilog/imct_master.sv
// isa bus master end: runs memory, system-memory and io cycles on the bus
// assumes one slave on imct_bus_if; the bus clock is made here from core_clk
`timescale 1ns/1ps

module imct_master (
  input  wire logic                core_clk,  // core clock, 10 MHz
  input  wire logic                nrst,      // asynchronous reset, active low
  input  wire logic                req,       // access request, held until ack
  input  wire imct_pkg::imct_kind_t req_kind, // memory, system memory or io
  input  wire logic                req_wr,    // 1 write, 0 read
  input  wire logic                req_w16,   // slave is 16 bits wide
  input  wire logic                req_zws,   // short cycle wanted
  input  wire logic [23:0]         req_addr,  // byte address
  input  wire logic [15:0]         req_wdata, // write data
  output logic                     ack,       // access finished, one cycle
  output logic [15:0]              rdata,     // read data, valid with ack
  output logic                     busy,      // access in progress
  imct_bus_if.master               bus        // isa bus pins
);
  import imct_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ALE  = 3'h1,
    ST_LEAD = 3'h3,
    ST_CMD  = 3'h2,
    ST_HOLD = 3'h6
  } imct_mst_t;

  typedef struct packed {
    imct_mst_t   st;
    logic [1:0]  div;
    logic        bclk;
    logic        rdy_m;
    logic        rdy_s;
    logic [15:0] sd_m;
    logic [15:0] sd_s;
    logic [5:0]  t;
    logic [5:0]  t_off;
    logic        rdy_ok;
    logic        io;
    logic        w16;
    logic        odd;
    imct_cyc_t   cyc;
    logic [5:0]  cmd_sel;
    logic [5:0]  cmd_n;
    logic        ale_n;
    logic [6:0]  la;
    logic [19:0] sa;
    logic        sbhe_n;
    logic [15:0] sd_o;
    logic        sd_oe;
    logic        ack;
    logic [15:0] rdata;
    logic        busy;
  } imct_mst_state_t;

  imct_mst_state_t r;
  imct_mst_state_t next_r;

  // ------------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------------

  // cycle length class from slave width and access type
  function automatic imct_cyc_t cyc_class(input logic w16, input logic io,
                                          input logic zws);
    if (w16)
      return zws ? IMCT_CYC2 : (io ? IMCT_CYC4 : IMCT_CYC3);
    return zws ? IMCT_CYC3 : IMCT_CYC7;
  endfunction

  // bus clock, counted from ale, at which the command may drop
  function automatic logic [5:0] off_at(input imct_cyc_t c);
    case (c)
      IMCT_CYC4: return 6'(ALE_TO_OFF_T + STRETCH4_T);
      IMCT_CYC7: return 6'(ALE_TO_OFF_T + STRETCH7_T);
      default:   return ALE_TO_OFF_T;
    endcase
  endfunction

  // one-hot strobe selection for a kind and direction
  function automatic logic [5:0] cmd_pick(input imct_kind_t k, input logic wr);
    logic [5:0] v;
    v = 6'h00;
    case (k)
      IMCT_SMEM: v[wr ? CMD_SMEMW : CMD_SMEMR] = 1'b1;
      IMCT_IO:   v[wr ? CMD_IOW : CMD_IOR] = 1'b1;
      default:   v[wr ? CMD_MEMW : CMD_MEMR] = 1'b1;
    endcase
    return v;
  endfunction

  // derived hold end points, counted from ale, except OFF_GAP_T counted from negation
  localparam logic [5:0] LA_END_T  = 6'(ALE_WIDTH_T + LA_AFTER_ALE_T);
  localparam logic [5:0] LA_END2_T = 6'(ALE_TO_CMD_T + LA_AFTER_CMD_T);
  localparam logic [5:0] SA_MEM_T  = 6'(ALE_TO_CMD_T + SA_AFTER_MEM_T);
  localparam logic [5:0] SA_IO_T   = 6'(ALE_TO_CMD_T + SA_AFTER_IO_T);
  localparam logic [5:0] NEXT_ALE_T = 6'(ALE_TO_CMD_T + CMD_TO_ALE_T);
  localparam logic [5:0] NEXT_CMD_T = 6'(CMD_REPEAT_T - ALE_TO_CMD_T);
  localparam logic [5:0] OFF_GAP_T  = 6'(OFF_TO_CMD_T - ALE_TO_CMD_T);

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic       tick;
    logic [5:0] nt;
    logic [5:0] nt_off;
    logic       hold_done;
    tick      = 1'b0;
    next_r    = r;
    next_r.ack = 1'b0;
    // bus clock divider; a tick is the rising edge of the bus clock
    if (r.div == BCLK_HALF_END) begin
      next_r.div  = 2'h0;
      next_r.bclk = !r.bclk;
      tick        = !r.bclk;
    end else begin
      next_r.div = 2'(r.div + 2'h1);
    end
    // pin inputs pass two flip-flops
    next_r.rdy_m = bus.iochrdy;
    next_r.rdy_s = r.rdy_m;
    next_r.sd_m  = bus.sd;
    next_r.sd_s  = r.sd_m;
    nt        = imct_inc(r.t);
    nt_off    = imct_inc(r.t_off);
    hold_done = (nt >= LA_END_T) && (nt >= LA_END2_T)
             && (nt >= (r.io ? SA_IO_T : SA_MEM_T))
             && (nt >= NEXT_ALE_T) && (nt >= NEXT_CMD_T)
             && (nt_off >= OFF_TO_ALE_T) && (nt_off >= OFF_GAP_T);
    if (tick) begin
      next_r.t     = nt;
      next_r.t_off = nt_off;
      case (r.st)
        ST_IDLE: begin
          if (req) begin
            next_r.t       = 6'h00;
            next_r.io      = (req_kind == IMCT_IO);
            next_r.w16     = req_w16;
            next_r.odd     = req_addr[0];
            next_r.cyc     = cyc_class(req_w16, req_kind == IMCT_IO, req_zws);
            next_r.cmd_sel = cmd_pick(req_kind, req_wr);
            next_r.ale_n   = 1'b0;
            next_r.la      = req_addr[23:17];
            next_r.sa      = req_addr[19:0];
            next_r.sbhe_n  = !(req_w16 || req_addr[0]);
            next_r.sd_o    = req_w16 ? req_wdata : {req_wdata[7:0], req_wdata[7:0]};
            next_r.sd_oe   = req_wr;
            next_r.busy    = 1'b1;
            next_r.st      = ST_ALE;
          end
        end
        ST_ALE: begin
          if (nt >= ALE_WIDTH_T) begin
            next_r.ale_n = 1'b1;
            next_r.st    = ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (nt >= ALE_TO_CMD_T) begin
            next_r.cmd_n  = ~r.cmd_sel;
            next_r.rdy_ok = 1'b0;
            next_r.st     = ST_CMD;
          end
        end
        ST_CMD: begin
          next_r.rdy_ok = r.rdy_s;
          // ready must have stood high since the previous bus clock
          if ((nt >= off_at(r.cyc)) && (nt >= 6'(ALE_TO_CMD_T + CMD_WIDTH_T))
              && (r.rdy_ok || (RDY_TO_OFF_T == 6'h00)) && r.rdy_s) begin
            next_r.cmd_n  = CMD_IDLE;
            next_r.t_off  = 6'h00;
            next_r.rdata  = r.w16 ? r.sd_s
                          : {8'h00, (r.odd ? r.sd_s[15:8] : r.sd_s[7:0])};
            next_r.st     = ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (nt_off >= WDATA_HOLD_T)
            next_r.sd_oe = 1'b0;
          if (hold_done && (nt_off >= WDATA_HOLD_T)) begin
            next_r.ack  = 1'b1;
            next_r.busy = 1'b0;
            next_r.st   = ST_IDLE;
          end
        end
        default: begin
          next_r.st    = ST_IDLE;
          next_r.cmd_n = CMD_IDLE;
          next_r.ale_n = 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r       <= '0;
      r.st    <= ST_IDLE;
      r.rdy_m <= 1'b1;
      r.rdy_s <= 1'b1;
      r.cyc   <= IMCT_CYC3;
      r.cmd_n <= CMD_IDLE;
      r.ale_n <= 1'b1;
      r.sbhe_n <= 1'b1;
      r.t     <= 6'h3f;
      r.t_off <= 6'h3f;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------------
  // outputs, all straight from the state register
  // ------------------------------------------------------------------
  assign bus.bclk    = r.bclk;
  assign bus.ale_n   = r.ale_n;
  assign bus.la      = r.la;
  assign bus.sa      = r.sa;
  assign bus.sbhe_n  = r.sbhe_n;
  assign bus.memr_n  = r.cmd_n[CMD_MEMR];
  assign bus.memw_n  = r.cmd_n[CMD_MEMW];
  assign bus.smemr_n = r.cmd_n[CMD_SMEMR];
  assign bus.smemw_n = r.cmd_n[CMD_SMEMW];
  assign bus.ior_n   = r.cmd_n[CMD_IOR];
  assign bus.iow_n   = r.cmd_n[CMD_IOW];
  assign bus.m_sd_o  = r.sd_o;
  assign bus.m_sd_oe = r.sd_oe;
  assign ack         = r.ack;
  assign rdata       = r.rdata;
  assign busy        = r.busy;

endmodule

// >>> verilog/imct_pkg.sv
// package of the isa master cycle timing block: bus clock and cycle counts
// assumes both ends count intervals in whole bus clock cycles (T)
package imct_pkg;

  // ------------------------------------------------------------------
  // bus clock made by the master from core_clk
  // ------------------------------------------------------------------
  localparam int          CORE_CLK_NS   = 100;   // core clock period
  localparam int          BCLK_NS       = 800;   // bus clock period
  localparam int          BCLK_HALF     = BCLK_NS / (2 * CORE_CLK_NS);
  localparam logic [1:0]  BCLK_HALF_END = 2'(BCLK_HALF - 1);

  // ------------------------------------------------------------------
  // master intervals in bus clocks, each from the event it names; ALE assertion is t=0
  // ------------------------------------------------------------------
  localparam logic [5:0] ALE_WIDTH_T    = 6'h01; // ale low before negation
  localparam logic [5:0] ALE_TO_CMD_T   = 6'h02; // ale to command asserted
  localparam logic [5:0] ALE_TO_OFF_T   = 6'h0b; // ale to command negated
  localparam logic [5:0] CMD_WIDTH_T    = 6'h09; // standard command width
  localparam logic [5:0] LA_AFTER_ALE_T = 6'h0e; // la held after ale negated
  localparam logic [5:0] LA_AFTER_CMD_T = 6'h0d; // la held after command
  localparam logic [5:0] SA_AFTER_MEM_T = 6'h0a; // sa held after mem command
  localparam logic [5:0] SA_AFTER_IO_T  = 6'h13; // sa held after io command
  localparam logic [5:0] CMD_TO_ALE_T   = 6'h0a; // command to next ale
  localparam logic [5:0] CMD_REPEAT_T   = 6'h0c; // command to next command
  localparam logic [5:0] OFF_TO_CMD_T   = 6'h03; // negation to next command
  localparam logic [5:0] OFF_TO_ALE_T   = 6'h01; // negation to next ale
  localparam logic [5:0] RDY_TO_OFF_T   = 6'h01; // ready high before negation
  localparam logic [5:0] STRETCH4_T     = 6'h01; // extra length, 4-clock cycle
  localparam logic [5:0] STRETCH7_T     = 6'h05; // extra length, 7-clock cycle
  localparam logic [5:0] WDATA_HOLD_T   = 6'h01; // write data after negation

  // ------------------------------------------------------------------
  // slave intervals in bus clocks, counted from ALE assertion
  // ------------------------------------------------------------------
  localparam logic [5:0] WAIT16_T = 6'h08; // 16-bit: ready low no sooner
  localparam logic [5:0] WAIT8_T  = 6'h0e; // 8-bit: ready low no sooner
  localparam logic [5:0] DATA16_T = 6'h04; // 16-bit read data valid
  localparam logic [5:0] DATA8_T  = 6'h0a; // 8-bit read data valid

  // command strobe bit positions in a 6-bit vector, all active low
  localparam int CMD_MEMR  = 0;
  localparam int CMD_MEMW  = 1;
  localparam int CMD_SMEMR = 2;
  localparam int CMD_SMEMW = 3;
  localparam int CMD_IOR   = 4;
  localparam int CMD_IOW   = 5;
  localparam logic [5:0] CMD_IDLE = 6'h3f;
  localparam logic [15:0] BUS_FLOAT = 16'hffff; // pulled-up data bus

  typedef enum logic [1:0] {
    IMCT_MEM  = 2'h0,
    IMCT_SMEM = 2'h1,
    IMCT_IO   = 2'h2
  } imct_kind_t;

  typedef enum logic [1:0] {
    IMCT_CYC2 = 2'h0,
    IMCT_CYC3 = 2'h1,
    IMCT_CYC4 = 2'h3,
    IMCT_CYC7 = 2'h2
  } imct_cyc_t;

  // saturating bus clock counter step
  function automatic logic [5:0] imct_inc(input logic [5:0] v);
    return (v == 6'h3f) ? v : 6'(v + 6'h01);
  endfunction

endpackage

// >>> verilog/imct_slave.sv
// isa bus slave end: sixteen-word memory with wait states and read data timing
// assumes the master on imct_bus_if makes the bus clock; all pins except la, sbhe_n and iochrdy sampled here
`timescale 1ns/1ps
module imct_slave (
  input  wire logic        core_clk,  // core clock, 10 MHz
  input  wire logic        nrst,      // asynchronous reset, active low
  input  wire logic        cfg_w16,   // answer as a 16-bit slave
  input  wire logic [3:0]  cfg_wait,  // wait states in bus clocks, 0 none
  output logic             done,      // access ended, one cycle
  output logic             done_wr,   // the ended access was a write
  output logic [15:0]      last_data, // data of the ended access
  imct_bus_if.slave        bus        // isa bus pins
);
  import imct_pkg::*;

  typedef enum logic [1:0] {
    SL_IDLE = 2'h0,
    SL_ADDR = 2'h1,
    SL_WAIT = 2'h3,
    SL_CMD  = 2'h2
  } imct_slv_t;

  typedef struct packed {
    imct_slv_t        st;
    logic [2:0]       bclk_p;   // sync pair plus edge history
    logic [1:0]       ale_p;
    logic [5:0]       cmd_m;
    logic [5:0]       cmd_s;
    logic [15:0]      sd_m;
    logic [15:0]      sd_s;
    logic [3:0]       idx_m;
    logic [3:0]       idx_s;
    logic [5:0]       t;
    logic [3:0]       wcnt;
    logic             waited;
    logic             seen;
    logic             wr;
    logic [15:0][15:0] mem;
    logic [15:0]      sd_o;
    logic             sd_oe;
    logic             rdy_oe;
    logic             done;
    logic             done_wr;
    logic [15:0]      last_data;
  } imct_slv_state_t;

  imct_slv_state_t r;
  imct_slv_state_t next_r;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic       tick;
    logic       cmd_on;
    logic       rd_on;
    next_r        = r;
    next_r.done   = 1'b0;
    next_r.bclk_p = {r.bclk_p[1:0], bus.bclk};
    next_r.ale_p  = {r.ale_p[0], bus.ale_n};
    next_r.cmd_m  = {bus.iow_n, bus.ior_n, bus.smemw_n, bus.smemr_n, bus.memw_n,
                     bus.memr_n};
    next_r.cmd_s  = r.cmd_m;
    next_r.sd_m   = bus.sd;
    next_r.sd_s   = r.sd_m;
    next_r.idx_m  = bus.sa[4:1];
    next_r.idx_s  = r.idx_m;
    tick   = r.bclk_p[1] && !r.bclk_p[2];
    cmd_on = (r.cmd_s != CMD_IDLE);
    rd_on  = !(r.cmd_s[CMD_MEMR] && r.cmd_s[CMD_SMEMR] && r.cmd_s[CMD_IOR]);
    if (tick)
      next_r.t = imct_inc(r.t);
    // read data once the width's delay from ale has passed
    if (rd_on && (r.t >= (cfg_w16 ? DATA16_T : DATA8_T))) begin
      next_r.sd_o  = cfg_w16 ? r.mem[r.idx_s] : {r.mem[r.idx_s][7:0], r.mem[r.idx_s][7:0]};
      next_r.sd_oe = 1'b1;
    end
    if (!rd_on)
      next_r.sd_oe = 1'b0;
    case (r.st)
      SL_IDLE: begin
        if (!r.ale_p[1]) begin
          next_r.t      = 6'h00;
          next_r.waited = 1'b0;
          next_r.seen   = 1'b0;
          next_r.st     = SL_ADDR;
        end
      end
      SL_ADDR: begin
        if (cmd_on) begin
          next_r.seen = 1'b1;
          next_r.wr   = !(r.cmd_s[CMD_MEMW] && r.cmd_s[CMD_SMEMW] && r.cmd_s[CMD_IOW]);
        end
        // ready drops no sooner than the width's delay after ale and la/sa
        if (tick && cmd_on && !r.waited && (cfg_wait != 4'h0)
            && (imct_inc(r.t) >= (cfg_w16 ? WAIT16_T : WAIT8_T))) begin
          next_r.rdy_oe = 1'b1;
          next_r.wcnt   = cfg_wait;
          next_r.st     = SL_WAIT;
        end else if (r.seen && !cmd_on) begin
          next_r.st = SL_CMD;
        end
      end
      SL_WAIT: begin
        if (tick) begin
          next_r.wcnt = 4'(r.wcnt - 4'h1);
          if (r.wcnt == 4'h1) begin
            next_r.rdy_oe = 1'b0;
            next_r.waited = 1'b1;
            next_r.st     = SL_ADDR;
          end
        end
      end
      SL_CMD: begin
        // command ended: store a write, report the access
        if (r.wr)
          next_r.mem[r.idx_s] = cfg_w16 ? r.sd_s : {8'h00, r.sd_s[7:0]};
        next_r.done      = 1'b1;
        next_r.done_wr   = r.wr;
        next_r.last_data = r.wr ? r.sd_s : r.sd_o;
        next_r.st        = SL_IDLE;
      end
      default: next_r.st = SL_IDLE;
    endcase
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r       <= '0;
      r.st    <= SL_IDLE;
      r.ale_p <= 2'h3;
      r.cmd_m <= CMD_IDLE;
      r.cmd_s <= CMD_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // outputs from the state register; ready only ever pulled low
  assign bus.s_sd_o   = r.sd_o;
  assign bus.s_sd_oe  = r.sd_oe;
  assign bus.s_rdy_o  = 1'b0;
  assign bus.s_rdy_oe = r.rdy_oe;
  assign done         = r.done;
  assign done_wr      = r.done_wr;
  assign last_data    = r.last_data;

endmodule
